// *** hdl/rft_ctrl.sv ***
// Frame flow control of a packet radio: states, frame buffer, events, random bits
`include "rft_params.svh"
// Notes on behaviour
// (RULE1) Entering radio off from sleep or reset starts one filter tuning cycle.
// (RULE2) Without sleep, software retunes filters in off, idle or listen every few minutes.
// (RULE3) Listen states keep searching the channel for incoming frames.
// (RULE4) A detected frame raises receive start when that event is enabled.
// (RULE5) Receive done is raised once the whole frame is stored.
// (RULE6) Software waits 32 us after receive start before reading the first byte.
// (RULE7) Software reads the buffer slower than bytes arrive during reception.
// (RULE8) Strobe pin or send command starts transmission in idle or auto-retry state.
// (RULE9) Transmit done is raised when the transmission has completed.
// (RULE10) The synchronization header is generated internally, without buffer content.
// (RULE11) Settling 16 us plus header 160 us; length byte must be written meanwhile.
// (RULE12) Software writes the buffer faster than bytes are sent.
// (RULE13) Transmit may start before the payload is written.
// (RULE14) A 2-bit random value is readable in the signal strength register.
// (RULE15) The random value refreshes every 1 us in basic receive with locked PLL.
// (RULE16) Random value reads zero when unlocked, diversity or reduced power receive.
// (RULE17) A rate field selects 250, 500, 1000 or 2000 kb/s payload.
// (RULE18) In transmission, rate choice touches nothing but payload byte timing.
// (RULE19) Header and length byte always go at 250 kb/s; payload at selected rate.
// (RULE20) No rate indication in frames; both nodes are set alike beforehand.
// (RULE21) At high rate the byte after the payload is energy, not link quality.
// (RULE22) Energy window is 8 symbols at standard rate, 32 us at high rates.
// (RULE23) Each event flag stays pending until software clears it.
module rft_ctrl import rft_pkg::*; (
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata_ff,
   input wire logic sleep_transmit_strobe,
   input wire logic pll_locked,
   input wire logic [1:0] noise_bits,
   input wire logic frame_detect,
   input wire logic rx_byte_valid,
   input wire logic [7:0] rx_byte,
   input wire logic rx_frame_end,
   input wire logic [7:0] energy_level,
   input wire logic [7:0] link_quality_value,
   output logic filter_tuning_ff,
   output logic ed_measure_ff,
   output logic tx_header_ff,
   output logic tx_high_rate_ff,
   output logic tx_byte_valid_ff,
   output logic [7:0] tx_byte_ff,
   output logic [2:0] event_flags_ff
);
   // ****************************************
   // Helpers
   // ****************************************
   function automatic logic [12:0] byte_cycles(input logic [1:0] rate);
      byte_cycles = 13'(`RFT_BYTE_STD_CYC) >> rate; // see (RULE17)
   endfunction

   function automatic rft_state_t cmd_state(input logic [4:0] cmd, input rft_state_t cur);
      unique case (cmd)
         `RFT_CMD_OFF: cmd_state = st_off;
         `RFT_CMD_SYNTH: cmd_state = st_synth_idle;
         `RFT_CMD_LISTEN: cmd_state = st_listen;
         `RFT_CMD_LISTEN_AACK: cmd_state = st_listen_aack;
         `RFT_CMD_TX_ARET: cmd_state = st_tx_aret;
         default: cmd_state = cur;
      endcase
   endfunction

   logic [7:0] fb_mem [128];
   rft_state_t state_ff, nxt_state;
   logic [12:0] cnt_ff, nxt_cnt;
   logic [12:0] ed_cnt_ff, nxt_ed_cnt;
   logic [6:0] rx_idx_ff, nxt_rx_idx;
   logic [6:0] tx_idx_ff, nxt_tx_idx;
   logic [6:0] fb_ptr_ff, nxt_fb_ptr;
   logic ret_alt_ff, nxt_ret_alt;
   logic [1:0] rate_ff, nxt_rate;
   logic [2:0] enable_ff, nxt_enable;
   logic div_en_ff, nxt_div_en;
   logic rpr_en_ff, nxt_rpr_en;
   logic [2:0] nxt_flags, ev_set, ev_clr;
   logic [7:0] nxt_rdata, nxt_tx_byte;
   logic nxt_ft, nxt_ed_meas, nxt_tx_valid, nxt_high;
   logic strobe_s1_ff, strobe_s2_ff, strobe_d_ff;
   logic strobe_rise, strobe_fall, tx_go, rng_run;
   logic mem_we;
   logic [6:0] mem_addr;
   logic [7:0] mem_wdata;
   logic [4:0] cmd;
   logic [1:0] rnd;

   // ****************************************
   // Random generator
   // ****************************************
   assign rng_run = pll_locked && !div_en_ff && !rpr_en_ff && // see (RULE16)
      (state_ff == st_listen || (state_ff == st_busy_rx && !ret_alt_ff));

   rft_rng u_rng (
      .ref_clk(ref_clk),
      .sys_rst(sys_rst),
      .run(rng_run),
      .noise_bits(noise_bits),
      .rnd_ff(rnd)
   );

   // ****************************************
   // Next state
   // ****************************************
   assign strobe_rise = strobe_s2_ff && !strobe_d_ff;
   assign strobe_fall = !strobe_s2_ff && strobe_d_ff;
   assign cmd = (reg_wr && reg_addr == `RFT_ADDR_STATE) ? reg_wdata[4:0] : `RFT_CMD_NOP;
   // Payload need not be present yet; only the state gates the start
   assign tx_go = (strobe_rise || cmd == `RFT_CMD_TX_START) && // see (RULE8) (RULE13)
      (state_ff == st_synth_idle || state_ff == st_tx_aret);

   always_comb begin
      nxt_state = state_ff;
      nxt_cnt = (cnt_ff != 13'h0) ? cnt_ff - 13'h1 : cnt_ff;
      nxt_ed_cnt = (ed_cnt_ff != 13'h0) ? ed_cnt_ff - 13'h1 : ed_cnt_ff;
      nxt_rx_idx = rx_idx_ff;
      nxt_tx_idx = tx_idx_ff;
      nxt_fb_ptr = fb_ptr_ff;
      nxt_ret_alt = ret_alt_ff;
      nxt_rate = rate_ff;
      nxt_enable = enable_ff;
      nxt_div_en = div_en_ff;
      nxt_rpr_en = rpr_en_ff;
      nxt_ft = 1'b0;
      nxt_tx_valid = 1'b0;
      nxt_tx_byte = tx_byte_ff;
      nxt_rdata = reg_rdata_ff;
      ev_set = 3'h0;
      ev_clr = 3'h0;
      mem_we = 1'b0;
      mem_addr = fb_ptr_ff;
      mem_wdata = reg_wdata;
      unique case (state_ff)
         st_sleep: begin
            if (strobe_fall || cmd == `RFT_CMD_OFF) begin
               nxt_state = st_off;
               nxt_ft = 1'b1; // see (RULE1)
            end
         end
         st_off: begin
            nxt_state = (strobe_rise || cmd == `RFT_CMD_SLEEP) ? st_sleep : cmd_state(cmd, state_ff);
         end
         st_synth_idle, st_tx_aret: begin
            if (tx_go) begin
               nxt_state = st_tx_settle;
               nxt_ret_alt = (state_ff == st_tx_aret);
               nxt_cnt = 13'(`RFT_SETTLE_CYC - 1); // see (RULE11)
            end else begin
               nxt_state = cmd_state(cmd, state_ff);
            end
         end
         st_listen, st_listen_aack: begin
            if (frame_detect) begin // see (RULE3)
               nxt_state = st_busy_rx;
               nxt_ret_alt = (state_ff == st_listen_aack);
               nxt_rx_idx = 7'h0;
               ev_set[`RFT_EV_RXS] = enable_ff[`RFT_EV_RXS]; // see (RULE4)
               nxt_ed_cnt = (rate_ff != 2'h0) ? 13'(`RFT_ED_HIGH_CYC - 1) : 13'(`RFT_ED_STD_CYC - 1); // see (RULE22)
            end else begin
               nxt_state = cmd_state(cmd, state_ff);
            end
         end
         st_busy_rx: begin
            // A lost lock abandons the frame without a done event
            if (!pll_locked || rx_frame_end) begin
               nxt_state = ret_alt_ff ? st_listen_aack : st_listen;
            end
            if (pll_locked && rx_frame_end) begin
               mem_we = 1'b1;
               mem_addr = rx_idx_ff;
               mem_wdata = (rate_ff != 2'h0) ? energy_level : link_quality_value; // see (RULE21)
               ev_set[`RFT_EV_RXD] = enable_ff[`RFT_EV_RXD]; // see (RULE5)
            end else if (pll_locked && rx_byte_valid) begin
               mem_we = 1'b1;
               mem_addr = rx_idx_ff;
               mem_wdata = rx_byte;
               nxt_rx_idx = rx_idx_ff + 7'h1;
            end
         end
         st_tx_settle: begin
            if (cnt_ff == 13'h0) begin
               nxt_state = st_tx_header;
               nxt_cnt = 13'(`RFT_SHR_CYC - 1); // see (RULE10) (RULE11)
            end
         end
         st_tx_header: begin
            if (cnt_ff == 13'h0) begin
               nxt_state = st_tx_data;
               nxt_tx_idx = 7'h0;
               nxt_cnt = 13'(`RFT_BYTE_STD_CYC - 1); // see (RULE19)
            end
         end
         st_tx_data: begin
            if (cnt_ff == 13'h0) begin
               nxt_tx_valid = 1'b1;
               nxt_tx_byte = fb_mem[tx_idx_ff];
               if (tx_idx_ff == (fb_mem[0][6:0] & `RFT_LEN_MASK)) begin
                  nxt_state = ret_alt_ff ? st_tx_aret : st_synth_idle;
                  ev_set[`RFT_EV_TXD] = enable_ff[`RFT_EV_TXD]; // see (RULE9)
               end else begin
                  nxt_tx_idx = tx_idx_ff + 7'h1;
                  nxt_cnt = byte_cycles(rate_ff) - 13'h1; // see (RULE18) (RULE19)
               end
            end
         end
      endcase
      // ****************************************
      // Register port
      // ****************************************
      if (reg_wr) begin
         unique case (reg_addr)
            `RFT_ADDR_XCVR2: nxt_rate = reg_wdata[1:0]; // see (RULE17) (RULE20)
            `RFT_ADDR_FLAGS: ev_clr = reg_wdata[2:0];
            `RFT_ADDR_ENABLE: nxt_enable = reg_wdata[2:0];
            `RFT_ADDR_MISC: begin
               nxt_div_en = reg_wdata[`RFT_MISC_DIV_BIT];
               nxt_rpr_en = reg_wdata[`RFT_MISC_RPR_BIT];
               if (state_ff == st_off || state_ff == st_synth_idle || state_ff == st_listen) begin
                  nxt_ft = nxt_ft | reg_wdata[`RFT_MISC_FT_BIT]; // see (RULE2)
               end
            end
            `RFT_ADDR_FBPTR: nxt_fb_ptr = reg_wdata[6:0];
            `RFT_ADDR_FBDATA: begin
               // Receive path owns the write port; a colliding host write is dropped
               if (!mem_we) begin
                  mem_we = 1'b1;
                  mem_addr = fb_ptr_ff;
                  mem_wdata = reg_wdata;
               end
               nxt_fb_ptr = fb_ptr_ff + 7'h1;
            end
            default: ;
         endcase
      end
      if (reg_rd) begin
         unique case (reg_addr)
            `RFT_ADDR_STATE: nxt_rdata = {4'h0, state_ff};
            `RFT_ADDR_XCVR2: nxt_rdata = {6'h0, rate_ff};
            `RFT_ADDR_SIGNAL: nxt_rdata = 8'(rnd) << `RFT_RND_LSB; // see (RULE14)
            `RFT_ADDR_FLAGS: nxt_rdata = {5'h0, event_flags_ff};
            `RFT_ADDR_ENABLE: nxt_rdata = {5'h0, enable_ff};
            `RFT_ADDR_MISC: nxt_rdata = {5'h0, rpr_en_ff, div_en_ff, 1'b0};
            `RFT_ADDR_FBPTR: nxt_rdata = {1'b0, fb_ptr_ff};
            `RFT_ADDR_FBDATA: begin
               nxt_rdata = fb_mem[fb_ptr_ff];
               nxt_fb_ptr = fb_ptr_ff + 7'h1;
            end
            default: nxt_rdata = 8'h00;
         endcase
      end
      nxt_flags = (event_flags_ff & ~ev_clr) | ev_set; // see (RULE23)
      nxt_ed_meas = (nxt_ed_cnt != 13'h0) || (ed_cnt_ff != 13'h0); // see (RULE22)
      nxt_high = nxt_tx_valid && tx_idx_ff != 7'h0 && rate_ff != 2'h0;
   end

   // ****************************************
   // Registers
   // ****************************************
   always_ff @(posedge ref_clk) begin
      if (mem_we) begin
         fb_mem[mem_addr] <= mem_wdata;
      end
   end

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         state_ff <= st_off;
         filter_tuning_ff <= 1'b1; // see (RULE1)
         cnt_ff <= 13'h0;
         ed_cnt_ff <= 13'h0;
         rx_idx_ff <= 7'h0;
         tx_idx_ff <= 7'h0;
         fb_ptr_ff <= 7'h0;
         ret_alt_ff <= 1'b0;
         rate_ff <= `RFT_RATE_RST;
         enable_ff <= `RFT_ENABLE_RST;
         div_en_ff <= 1'b0;
         rpr_en_ff <= 1'b0;
         event_flags_ff <= 3'h0;
         reg_rdata_ff <= 8'h00;
         ed_measure_ff <= 1'b0;
         tx_header_ff <= 1'b0;
         tx_high_rate_ff <= 1'b0;
         tx_byte_valid_ff <= 1'b0;
         tx_byte_ff <= 8'h00;
         strobe_s1_ff <= 1'b0;
         strobe_s2_ff <= 1'b0;
         strobe_d_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         filter_tuning_ff <= nxt_ft;
         cnt_ff <= nxt_cnt;
         ed_cnt_ff <= nxt_ed_cnt;
         rx_idx_ff <= nxt_rx_idx;
         tx_idx_ff <= nxt_tx_idx;
         fb_ptr_ff <= nxt_fb_ptr;
         ret_alt_ff <= nxt_ret_alt;
         rate_ff <= nxt_rate;
         enable_ff <= nxt_enable;
         div_en_ff <= nxt_div_en;
         rpr_en_ff <= nxt_rpr_en;
         event_flags_ff <= nxt_flags;
         reg_rdata_ff <= nxt_rdata;
         ed_measure_ff <= nxt_ed_meas;
         tx_header_ff <= (nxt_state == st_tx_header);
         tx_high_rate_ff <= nxt_high;
         tx_byte_valid_ff <= nxt_tx_valid;
         tx_byte_ff <= nxt_tx_byte;
         strobe_s1_ff <= sleep_transmit_strobe;
         strobe_s2_ff <= strobe_s1_ff;
         strobe_d_ff <= strobe_s2_ff;
      end
   end

   // ****************************************
   // Checks
   // ****************************************
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (sys_rst);

   ft_on_wake_a: assert property (state_ff == st_off && $past(state_ff) == st_sleep |-> filter_tuning_ff) // see (RULE1)
      else $error("no filter tuning on wake");
   rx_start_a: assert property ((state_ff == st_listen || state_ff == st_listen_aack) && frame_detect // see (RULE4)
      && enable_ff[`RFT_EV_RXS] |=> event_flags_ff[`RFT_EV_RXS] && state_ff == st_busy_rx)
      else $error("receive start not raised");
   rx_done_a: assert property (state_ff == st_busy_rx && rx_frame_end && pll_locked // see (RULE5)
      && enable_ff[`RFT_EV_RXD] |=> event_flags_ff[`RFT_EV_RXD] && state_ff != st_busy_rx)
      else $error("receive done not raised");
   tx_go_a: assert property (tx_go |=> state_ff == st_tx_settle ##0 cnt_ff == 13'(`RFT_SETTLE_CYC - 1)) // see (RULE8)
      else $error("transmit start ignored");
   hdr_load_a: assert property (state_ff == st_tx_settle && cnt_ff == 13'h0 // see (RULE11)
      |=> state_ff == st_tx_header && cnt_ff == 13'(`RFT_SHR_CYC - 1) && tx_header_ff)
      else $error("header phase length wrong");
   hdr_silent_a: assert property (state_ff == st_tx_settle || state_ff == st_tx_header |-> !tx_byte_valid_ff) // see (RULE10)
      else $error("buffer byte sent during header");
   phr_rate_a: assert property (state_ff == st_tx_data && cnt_ff == 13'h0 && tx_idx_ff == 7'h0 // see (RULE19)
      |=> tx_byte_valid_ff && !tx_high_rate_ff)
      else $error("length byte not at standard rate");
   trailer_ed_a: assert property (state_ff == st_busy_rx && rx_frame_end && pll_locked && rate_ff != 2'h0 // see (RULE21)
      |=> fb_mem[$past(rx_idx_ff)] == $past(energy_level))
      else $error("energy byte not stored after payload");
   ed_len_a: assert property (state_ff == st_listen && frame_detect |=> ed_measure_ff ##0 // see (RULE22)
      ed_cnt_ff == ((rate_ff != 2'h0) ? 13'(`RFT_ED_HIGH_CYC - 1) : 13'(`RFT_ED_STD_CYC - 1)))
      else $error("energy window length wrong");
   flag_hold_a: assert property (event_flags_ff[`RFT_EV_TXD] && !(reg_wr && reg_addr == `RFT_ADDR_FLAGS) // see (RULE23)
      |=> event_flags_ff[`RFT_EV_TXD])
      else $error("transmit done flag lost");

   rx_frame_c: cover property (state_ff == st_busy_rx ##[1:1000] event_flags_ff[`RFT_EV_RXD]);
   tx_frame_c: cover property (tx_go ##[1:1000] state_ff == st_tx_header);
   wake_c: cover property (state_ff == st_sleep ##[1:50] filter_tuning_ff);
endmodule // rft_ctrl

// *** hdl/rft_params.svh ***
// Constants for the radio frame transfer control block
`ifndef RFT_PARAMS_SVH
`define RFT_PARAMS_SVH

// ****************************************
// Register offsets
// ****************************************
`define RFT_ADDR_STATE 8'h00
`define RFT_ADDR_XCVR2 8'h01
`define RFT_ADDR_SIGNAL 8'h02
`define RFT_ADDR_FLAGS 8'h03
`define RFT_ADDR_ENABLE 8'h04
`define RFT_ADDR_MISC 8'h05
`define RFT_ADDR_FBPTR 8'h06
`define RFT_ADDR_FBDATA 8'h07

// ****************************************
// Fields and reset values
// ****************************************
`define RFT_RND_LSB 5
`define RFT_MISC_FT_BIT 0
`define RFT_MISC_DIV_BIT 1
`define RFT_MISC_RPR_BIT 2
`define RFT_EV_RXS 0
`define RFT_EV_RXD 1
`define RFT_EV_TXD 2
`define RFT_RATE_RST 2'h0
`define RFT_ENABLE_RST 3'h7
`define RFT_LEN_MASK 7'h7f

// ****************************************
// State commands
// ****************************************
`define RFT_CMD_NOP 5'h00
`define RFT_CMD_TX_START 5'h02
`define RFT_CMD_OFF 5'h08
`define RFT_CMD_SYNTH 5'h09
`define RFT_CMD_LISTEN 5'h06
`define RFT_CMD_LISTEN_AACK 5'h16
`define RFT_CMD_TX_ARET 5'h19
`define RFT_CMD_SLEEP 5'h0f

// ****************************************
// Timing
// ****************************************
`define RFT_CLK_MHZ 25
`define RFT_PLL_SETTLE_US 16
`define RFT_SHR_US 160
`define RFT_BYTE_STD_US 32
`define RFT_SYMBOL_US 16
`define RFT_ED_SYMBOLS 8
`define RFT_ED_HIGH_US 32
`define RFT_RND_US 1
`define RFT_SETTLE_CYC (`RFT_PLL_SETTLE_US * `RFT_CLK_MHZ)
`define RFT_SHR_CYC (`RFT_SHR_US * `RFT_CLK_MHZ)
`define RFT_BYTE_STD_CYC (`RFT_BYTE_STD_US * `RFT_CLK_MHZ)
`define RFT_ED_STD_CYC (`RFT_ED_SYMBOLS * `RFT_SYMBOL_US * `RFT_CLK_MHZ)
`define RFT_ED_HIGH_CYC (`RFT_ED_HIGH_US * `RFT_CLK_MHZ)
`define RFT_RND_CYC (`RFT_RND_US * `RFT_CLK_MHZ)

`endif

// *** hdl/rft_pkg.sv ***
// Types shared by the radio frame transfer control block
package rft_pkg;
   typedef enum logic [3:0] {
      st_sleep, st_off, st_synth_idle, st_listen, st_listen_aack, st_busy_rx,
      st_tx_aret, st_tx_settle, st_tx_header, st_tx_data
   } rft_state_t;
endpackage

// *** hdl/rft_rng.sv ***
// Two-bit noise sampling random generator
`include "rft_params.svh"
module rft_rng (
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic run,
   input wire logic [1:0] noise_bits,
   output logic [1:0] rnd_ff
);
   logic [1:0] noise_s1_ff;
   logic [1:0] noise_s2_ff;
   logic [4:0] tick_ff;
   logic [4:0] nxt_tick;
   logic [1:0] nxt_rnd;

   always_comb begin
      nxt_tick = tick_ff;
      nxt_rnd = rnd_ff;
      if (!run) begin
         nxt_tick = 5'h0;
         nxt_rnd = 2'h0; // see (RULE16)
      end else if (tick_ff == 5'(`RFT_RND_CYC - 1)) begin
         nxt_tick = 5'h0;
         nxt_rnd = noise_s2_ff; // see (RULE15)
      end else begin
         nxt_tick = tick_ff + 5'h1;
      end
   end

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         noise_s1_ff <= 2'h0;
         noise_s2_ff <= 2'h0;
         tick_ff <= 5'h0;
         rnd_ff <= 2'h0;
      end else begin
         noise_s1_ff <= noise_bits;
         noise_s2_ff <= noise_s1_ff;
         tick_ff <= nxt_tick;
         rnd_ff <= nxt_rnd;
      end
   end

   rnd_zero_a: assert property (@(posedge ref_clk) disable iff (sys_rst) !run |=> rnd_ff == 2'h0) // see (RULE16)
      else $error("random bits not zero while stopped");
   rnd_hold_a: assert property (@(posedge ref_clk) disable iff (sys_rst) // see (RULE15)
      run && $past(run) && tick_ff != 5'h0 |-> $stable(rnd_ff))
      else $error("random bits changed between refresh ticks");
endmodule // rft_rng

// *** testbench/rft_host.sv ***
// Host software model driving the register port of the frame control block
module rft_host (
   input wire logic ref_clk,
   input wire logic [7:0] reg_rdata_ff,
   output logic [7:0] reg_addr,
   output logic [7:0] reg_wdata,
   output logic reg_wr,
   output logic reg_rd
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
   end
   // ****************************************
   // Single-cycle register accesses
   // ****************************************
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask
   // Read data appear in the cycle after the strobe and hold until the next read
   task automatic rd(input logic [7:0] a, output logic [7:0] v);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1;
      v = reg_rdata_ff;
   endtask
endmodule // rft_host

// *** testbench/tb.sv ***
// Self-checking bench of the radio frame transfer control block
`include "rft_params.svh"
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic ref_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic sleep_transmit_strobe = 1'b0;
   logic pll_locked = 1'b1;
   logic frame_detect = 1'b0;
   logic rx_byte_valid = 1'b0;
   logic rx_frame_end = 1'b0;
   logic [7:0] rx_byte = 8'h00;
   logic [1:0] noise = 2'h3;
   logic [7:0] reg_addr, reg_wdata, reg_rdata_ff, tx_byte_ff, d;
   logic reg_wr, reg_rd, filter_tuning_ff, ed_measure_ff, tx_header_ff, tx_high_rate_ff, tx_byte_valid_ff;
   logic [2:0] event_flags_ff;
   int mismatches = 0;
   int check_count = 0;
   initial forever #20 ref_clk = ~ref_clk;
   rft_host u_host (.ref_clk(ref_clk), .reg_rdata_ff(reg_rdata_ff), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd));
   rft_ctrl u_dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff), .sleep_transmit_strobe(sleep_transmit_strobe),
      .pll_locked(pll_locked), .noise_bits(noise), .frame_detect(frame_detect), .rx_byte_valid(rx_byte_valid),
      .rx_byte(rx_byte), .rx_frame_end(rx_frame_end), .energy_level(8'h3c), .link_quality_value(8'hc3),
      .filter_tuning_ff(filter_tuning_ff), .ed_measure_ff(ed_measure_ff), .tx_header_ff(tx_header_ff),
      .tx_high_rate_ff(tx_high_rate_ff), .tx_byte_valid_ff(tx_byte_valid_ff), .tx_byte_ff(tx_byte_ff),
      .event_flags_ff(event_flags_ff));
   // ****************************************
   // Checking and run control
   // ****************************************
   task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp) begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic complete_run();
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic tick();
      @(posedge ref_clk);
      #1;
   endtask
   // Kind 0 frame found, 1 byte, 2 frame end
   task automatic rx_pulse(input int kind, input logic [7:0] b);
      @(posedge ref_clk);
      frame_detect <= (kind == 0);
      rx_byte_valid <= (kind == 1);
      rx_frame_end <= (kind == 2);
      rx_byte <= b;
      tick();
      frame_detect <= 1'b0;
      rx_byte_valid <= 1'b0;
      rx_frame_end <= 1'b0;
   endtask
   task automatic see_tune(input string what);
      logic seen;
      seen = 1'b0;
      repeat (4) begin
         #1;
         seen |= filter_tuning_ff;
         @(posedge ref_clk);
      end
      chk(what, {15'h0, seen}, 16'h1);
   endtask
   // ****************************************
   // Scenarios
   // ****************************************
   task automatic t_reset();
      logic [7:0] adr [5] = '{`RFT_ADDR_STATE, `RFT_ADDR_XCVR2, `RFT_ADDR_FLAGS, `RFT_ADDR_ENABLE, 8'h20};
      logic [7:0] val [5] = '{8'h01, 8'h00, 8'h00, 8'h07, 8'h00};
      repeat (8) @(posedge ref_clk);
      #1;
      chk("tuning in reset", {15'h0, filter_tuning_ff}, 16'h1);
      @(posedge ref_clk);
      sys_rst <= 1'b0;
      tick();
      chk("tuning after reset", {15'h0, filter_tuning_ff}, 16'h0);
      for (int i = 0; i < 5; i++) begin
         u_host.rd(adr[i], d);
         chk("reset value", d, val[i]);
      end
      u_host.wr(`RFT_ADDR_STATE, {3'h0, `RFT_CMD_TX_START});
      u_host.rd(`RFT_ADDR_STATE, d);
      chk("start refused in off", d, 8'h01);
      u_host.wr(`RFT_ADDR_STATE, {3'h0, `RFT_CMD_SLEEP});
      u_host.rd(`RFT_ADDR_STATE, d);
      chk("sleep state", d, 8'h00);
      u_host.wr(`RFT_ADDR_STATE, {3'h0, `RFT_CMD_OFF});
      see_tune("tuning on wake");
      u_host.wr(`RFT_ADDR_MISC, 8'h01);
      see_tune("manual tuning");
      $display("test reset done");
   endtask
   task automatic t_rng();
      u_host.wr(`RFT_ADDR_STATE, {3'h0, `RFT_CMD_LISTEN});
      repeat (60) @(posedge ref_clk);
      u_host.rd(`RFT_ADDR_SIGNAL, d);
      chk("random bits", d, 8'h60);
      noise <= 2'h1;
      repeat (60) @(posedge ref_clk);
      u_host.rd(`RFT_ADDR_SIGNAL, d);
      chk("random refresh", d, 8'h20);
      @(posedge ref_clk);
      pll_locked <= 1'b0;
      repeat (30) @(posedge ref_clk);
      u_host.rd(`RFT_ADDR_SIGNAL, d);
      chk("random unlocked", d, 8'h00);
      @(posedge ref_clk);
      pll_locked <= 1'b1;
      for (int i = 1; i < 3; i++) begin
         u_host.wr(`RFT_ADDR_MISC, 8'h01 << i);
         repeat (30) @(posedge ref_clk);
         u_host.rd(`RFT_ADDR_SIGNAL, d);
         chk("random diversity or low power", d, 8'h00);
      end
      u_host.wr(`RFT_ADDR_MISC, 8'h00);
      $display("test random done");
   endtask
   task automatic t_rx(input logic [1:0] rate, input logic [2:0] en, input logic [4:0] cmd);
      int n;
      logic [7:0] exp [4];
      exp = '{8'h02, 8'ha5, 8'h5a, (rate != 2'h0) ? 8'h3c : 8'hc3};
      n = 0;
      u_host.wr(`RFT_ADDR_STATE, {3'h0, cmd});
      u_host.wr(`RFT_ADDR_XCVR2, {6'h00, rate});
      u_host.wr(`RFT_ADDR_ENABLE, {5'h00, en});
      rx_pulse(0, 8'h00);
      chk("rx start flag", {15'h0, event_flags_ff[0]}, {15'h0, en[0]});
      while (ed_measure_ff === 1'b1 && n < 4000) begin
         n++;
         tick();
      end
      chk("energy window", n[15:0], (rate != 2'h0) ? 16'd800 : 16'd3200);
      for (int i = 0; i < 3; i++) rx_pulse(1, exp[i]);
      rx_pulse(2, 8'h00);
      chk("rx done flag", {15'h0, event_flags_ff[1]}, 16'h1);
      // Buffer read only after the frame is complete
      u_host.wr(`RFT_ADDR_FBPTR, 8'h00);
      for (int i = 0; i < 4; i++) begin
         u_host.rd(`RFT_ADDR_FBDATA, d);
         chk("rx buffer", d, exp[i]);
      end
      u_host.wr(`RFT_ADDR_FLAGS, 8'h01);
      u_host.rd(`RFT_ADDR_FLAGS, d);
      chk("flags kept apart", d, 8'h02);
      u_host.wr(`RFT_ADDR_FLAGS, 8'h07);
      u_host.wr(`RFT_ADDR_ENABLE, 8'h07);
      $display("test receive done");
   endtask
   task automatic t_tx(input logic [1:0] rate, input logic strobe);
      int n;
      logic [4:0] home;
      home = strobe ? `RFT_CMD_TX_ARET : `RFT_CMD_SYNTH;
      n = 0;
      u_host.wr(`RFT_ADDR_STATE, {3'h0, `RFT_CMD_OFF});
      u_host.wr(`RFT_ADDR_STATE, {3'h0, home});
      u_host.wr(`RFT_ADDR_XCVR2, {6'h00, rate});
      if (strobe) begin
         @(posedge ref_clk);
         sleep_transmit_strobe <= 1'b1;
         repeat (4) @(posedge ref_clk);
         sleep_transmit_strobe <= 1'b0;
      end else begin
         u_host.wr(`RFT_ADDR_STATE, {3'h0, `RFT_CMD_TX_START});
      end
      // Frame is written only after the start, inside the settle time
      u_host.wr(`RFT_ADDR_FBPTR, 8'h00);
      u_host.wr(`RFT_ADDR_FBDATA, 8'h01);
      u_host.wr(`RFT_ADDR_FBDATA, 8'h96);
      while (tx_header_ff !== 1'b1 && n < 1000) begin
         n++;
         tick();
      end
      chk("header started", {15'h0, tx_header_ff}, 16'h1);
      n = 0;
      while (tx_header_ff === 1'b1 && n < 5000) begin
         n++;
         tick();
      end
      chk("header length", n[15:0], 16'd4000);
      n = 0;
      while (tx_byte_valid_ff !== 1'b1 && n < 2000) begin
         n++;
         tick();
      end
      chk("length byte gap", n[15:0], 16'd800);
      chk("length byte", {7'h0, tx_high_rate_ff, tx_byte_ff}, 16'h0001);
      n = 1;
      tick();
      while (tx_byte_valid_ff !== 1'b1 && n < 2000) begin
         n++;
         tick();
      end
      chk("payload gap", n[15:0], 16'd800 >> rate);
      chk("payload byte", {7'h0, tx_high_rate_ff, tx_byte_ff}, {7'h0, rate != 2'h0, 8'h96});
      tick();
      chk("tx done flag", {13'h0, event_flags_ff}, 16'h4);
      u_host.wr(`RFT_ADDR_FLAGS, 8'h04);
      u_host.rd(`RFT_ADDR_STATE, d);
      chk("state after send", d, strobe ? 8'h06 : 8'h02);
      $display("test transmit done");
   endtask
   initial begin
      t_reset();
      t_rng();
      t_rx(2'h0, 3'h7, `RFT_CMD_LISTEN);
      t_rx(2'h2, 3'h6, `RFT_CMD_LISTEN_AACK);
      t_tx(2'h1, 1'b0);
      t_tx(2'h3, 1'b1);
      complete_run();
   end
endmodule // tb
